/* core/general_purpose_16bit_timer.sv */
// Top of the 16-bit timer: APB registers, clock select, counter and interrupt.
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/100ps
module general_purpose_16bit_timer
  import timer_pkg::*;
#(
  parameter int COUNT_WIDTH = 16
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // External clock sources and gate
  input  wire logic        generic_timer_input,
  input  wire logic        low_power_rc_osc,
  input  wire logic        dedicated_clock_pin,
  input  wire logic        secondary_osc,
  input  wire logic        gate_in,
  // Chip power state
  input  wire logic        cpu_idle,
  // Outputs
  output logic             irq,
  output logic             rtc_tick
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0]            timer_control_reg;
  logic [COUNT_WIDTH-1:0] period_value_reg;
  logic [COUNT_WIDTH-1:0] count_reg;
  logic [IRQ_WIDTH-1:0]   irq_status_reg;
  logic [IRQ_WIDTH-1:0]   irq_mask_reg;
  logic                   half_reg;
  timer_cfg_t             cfg;

  logic apb_access;
  logic apb_write;
  logic ctrl_write;
  logic known_addr;

  // Decodes whether an offset is a mapped register.
  // Shared by the write decode and the error response.
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == CONTROL_OFFSET) || (addr == PERIOD_OFFSET) || (addr == COUNT_OFFSET) ||
                (addr == IRQ_STATUS_OFFSET) || (addr == IRQ_MASK_OFFSET);
  endfunction

  // Access phase decode; the slave takes the access in the first access cycle and answers one cycle later.
  // Gating with pready stops a second take while the answer stands.
  assign apb_access = psel && penable && !pready;
  assign apb_write  = apb_access && pwrite && is_mapped(paddr);
  assign ctrl_write = apb_write && (paddr == CONTROL_OFFSET);
  assign known_addr = is_mapped(paddr);

  // Control word fields.
  // This is only a view of the control register and holds no state.
  assign cfg.run                 = timer_control_reg[RUN_BIT];
  assign cfg.idle_halt           = timer_control_reg[IDLE_HALT_BIT];
  assign cfg.ext_source_select   = ext_src_t'(timer_control_reg[EXT_SRC_LSB +: 2]);
  assign cfg.gated_accumulate    = timer_control_reg[GATE_BIT];
  assign cfg.prescale_select     = timer_control_reg[PRESCALE_LSB +: 2];
  assign cfg.ext_clock_sync      = timer_control_reg[SYNC_BIT];
  assign cfg.clock_source_select = timer_control_reg[SRC_BIT];

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------

  // Ready and error pulse for one cycle per access.
  // One wait state: ready rises the cycle after the first access cycle.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_access;
      pslverr <= apb_access && !known_addr;
    end
  end

  // Read data, zero for unmapped offsets and unimplemented bits.
  // The value holds until the next read, so a slow master still sees it.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (apb_access && !pwrite) begin
      unique case (paddr)
        CONTROL_OFFSET:    prdata <= {16'h0000, timer_control_reg}; // see RULE11
        PERIOD_OFFSET:     prdata <= 32'(period_value_reg);
        COUNT_OFFSET:      prdata <= 32'(count_reg);
        IRQ_STATUS_OFFSET: prdata <= 32'(irq_status_reg);
        IRQ_MASK_OFFSET:   prdata <= 32'(irq_mask_reg);
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Control register; only implemented bits take writes.
  // Reserved bits are dropped on the way in, so reads need no gating.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      timer_control_reg <= CONTROL_RESET;
    end else if (ctrl_write) begin
      timer_control_reg <= pwdata[15:0] & CONTROL_WMASK; // see RULE4, see RULE11
    end
  end

  // Period and mask registers.
  // A period below the count only matches after the count wraps at the top.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      period_value_reg <= COUNT_WIDTH'(PERIOD_RESET);
      irq_mask_reg     <= '0;
    end else if (apb_write) begin
      if (paddr == PERIOD_OFFSET) begin
        period_value_reg <= pwdata[COUNT_WIDTH-1:0];
      end
      if (paddr == IRQ_MASK_OFFSET) begin
        irq_mask_reg <= pwdata[IRQ_WIDTH-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------
  logic [3:0] ext_level;
  logic [3:0] ext_rise;
  logic       gate_level;
  logic       gate_fall;
  logic       raw_sel_reg;
  logic       raw_last_reg;
  logic       sel_level;
  logic       sel_rise;
  logic       src_tick;
  logic       pre_tick;
  logic       enabled;
  logic       gated;

  // Synchronisers for the four external sources.
  // Each source keeps its own synchroniser, so a switch needs no settling.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ext
      logic src_pin;
      assign src_pin = (gi == 0) ? secondary_osc : (gi == 1) ? dedicated_clock_pin :
                       (gi == 2) ? low_power_rc_osc : generic_timer_input;
      timer_edge_sync u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (src_pin),
        .level    (ext_level[gi]),
        .rise     (ext_rise[gi]),
        .fall     ()
      );
    end
  endgenerate

  // Gate input synchroniser.
  // Its falling edge shows about two cycles after the pin falls.
  timer_edge_sync u_gate_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (gate_in),
    .level    (gate_level),
    .rise     (),
    .fall     (gate_fall)
  );

  // Unsynchronized path: one extra flop behind the selected synchronised level.
  // Pins still pass two flops first, so this mode differs only in lag, never in safety.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      raw_sel_reg  <= 1'b0;
      raw_last_reg <= 1'b0;
    end else begin
      raw_sel_reg  <= ext_level[cfg.ext_source_select]; // see RULE6
      raw_last_reg <= raw_sel_reg;
    end
  end

  // Internal clock is core_clk divided by two.
  // It runs freely, so the first tick after a start may come a cycle late.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      half_reg <= 1'b0;
    end else begin
      half_reg <= ~half_reg; // see RULE10
    end
  end

  // Chooses the source tick for the prescaler.
  // An external clock must stay below half the core rate to be counted.
  always_comb begin
    sel_level = raw_sel_reg;
    sel_rise  = raw_sel_reg & ~raw_last_reg;
    if (!cfg.clock_source_select) begin
      src_tick = half_reg; // see RULE10, see RULE1
    end else if (cfg.ext_clock_sync) begin
      src_tick = ext_rise[cfg.ext_source_select]; // see RULE9, see RULE6
    end else begin
      src_tick = sel_rise && sel_level; // see RULE9
    end
  end

  // Timer runs in sleep; idle halts it only if asked.
  // Sleep does not stop core_clk here, so only the idle halt can hold it.
  assign enabled = cfg.run && !(cfg.idle_halt && cpu_idle); // see RULE5, see RULE13
  assign gated   = cfg.gated_accumulate && !cfg.clock_source_select; // see RULE7

  // Prescaler, cleared by any control write.
  // Gate and idle act on its input, so the divider keeps its phase while held.
  timer_prescaler u_prescaler (
    .core_clk        (core_clk),
    .rst             (rst),
    .clear           (ctrl_write || !cfg.run), // see RULE14
    .in_tick         (src_tick && enabled && (!gated || gate_level)), // see RULE16
    .prescale_select (cfg.prescale_select),
    .out_tick        (pre_tick)
  );

  // ----------------------------------------------------------------
  // Counter and events
  // ----------------------------------------------------------------
  logic match_event;
  logic gate_event;

  // The compare sees the count before the step: period P gives P+1 ticks.
  assign match_event = pre_tick && (count_reg == period_value_reg); // see RULE15, see RULE2
  assign gate_event  = gated && cfg.run && gate_fall; // see RULE16, see RULE2

  // Counter increments per tick and wraps on period match.
  // A software load beats a tick in the same cycle, so a loaded count is kept.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_reg <= '0;
    end else if (apb_write && paddr == COUNT_OFFSET) begin
      count_reg <= pwdata[COUNT_WIDTH-1:0];
    end else if (match_event) begin
      count_reg <= '0; // see RULE15
    end else if (pre_tick) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // Sticky status, write one to clear; a new event wins.
  // A clear that meets an event loses, so no event is ever dropped.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_status_reg <= '0;
    end else begin
      for (int i = 0; i < IRQ_WIDTH; i++) begin
        if ((i == IRQ_MATCH_BIT && match_event) || (i == IRQ_GATE_BIT && gate_event)) begin
          irq_status_reg[i] <= 1'b1;
        end else if (apb_write && paddr == IRQ_STATUS_OFFSET && pwdata[i]) begin
          irq_status_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt output, high while an unmasked status bit stands.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_mask_reg); // see RULE2
    end
  end

  // Real-time-clock time base, one pulse a cycle after each period match.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rtc_tick <= 1'b0;
    end else begin
      rtc_tick <= match_event; // see RULE12
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Counter path.
  a_match_wraps_count: assert property (match_event |=> count_reg == '0) // see RULE15
    else $error("Count did not wrap after period match.");
  a_count_steps: assert property (pre_tick && !match_event && !apb_write |=> // see RULE15
                                  count_reg == $past(count_reg) + 1'b1)
    else $error("Count did not step by one.");
  a_stopped_holds: assert property (!enabled && !apb_write |=> $stable(count_reg)) // see RULE4
    else $error("Count moved while stopped.");
  a_idle_halts: assert property (cfg.idle_halt && cpu_idle && !apb_write |=> $stable(count_reg)) // see RULE5
    else $error("Count moved while halted in idle.");
  a_gate_low_stall: assert property (gated && !gate_level && !apb_write |=> $stable(count_reg)) // see RULE16
    else $error("Count moved while gate low.");

  // Interrupt path.
  a_match_sets_flag: assert property (match_event |=> irq_status_reg[IRQ_MATCH_BIT]) // see RULE2
    else $error("Match flag not set.");
  a_gate_fall_flag: assert property (gate_event |=> irq_status_reg[IRQ_GATE_BIT]) // see RULE16
    else $error("Gate fall flag not set.");
  a_status_sticky: assert property (irq_status_reg[IRQ_MATCH_BIT] && !apb_write |=> // see RULE2
                                    irq_status_reg[IRQ_MATCH_BIT])
    else $error("Match flag lost without a clear.");
  a_irq_follows_mask: assert property (irq_status_reg[0] && irq_mask_reg[0] |=> irq) // see RULE2
    else $error("Interrupt not raised.");
  a_irq_masked_low: assert property ((irq_status_reg & irq_mask_reg) == '0 |=> !irq) // see RULE2
    else $error("Interrupt raised with nothing unmasked.");
  a_rtc_pulse: assert property (match_event |=> rtc_tick) // see RULE12
    else $error("Time base pulse missing after match.");

  // Control and register bus.
  a_reserved_zero: assert property ((timer_control_reg & ~CONTROL_WMASK) == 16'h0000) // see RULE11
    else $error("Unimplemented control bit set.");
  a_ctrl_write_clear: assert property (ctrl_write |=> cfg.prescale_select == 2'h0 || !pre_tick) // see RULE14
    else $error("Prescaler not cleared by control write.");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("Ready held more than one cycle.");
  a_unmapped_error: assert property (apb_access && !known_addr |=> pslverr)
    else $error("No error for an unmapped offset.");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("Error shown without ready.");

  // Main scenarios reached.
  c_match: cover property (match_event);
  c_gate_event: cover property (gate_event);
  c_ext_sync_tick: cover property (cfg.clock_source_select && cfg.ext_clock_sync && pre_tick);
  c_irq_raised: cover property (!irq ##1 irq);
  c_idle_halted: cover property (cfg.run && cfg.idle_halt && cpu_idle);

endmodule

/* core/timer_edge_sync.sv */
// Two-flop synchroniser with rising and falling edge detect.
`timescale 1ns/100ps
module timer_edge_sync
  import timer_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Asynchronous level in, synchronous level and edges out
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // Meta flop feeds only the second flop.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // Edges derived from the stable copies.
  assign level = sync_reg;
  assign rise  = sync_reg & ~last_reg;
  assign fall  = ~sync_reg & last_reg;

endmodule

/* core/timer_pkg.sv */
// Package with register map, field positions, reset values and shared types of the 16-bit timer.
//
// Notes on behaviour
// RULE1 - The counter runs as an internally clocked timer, a synchronous external counter or an asynchronous external counter.
// RULE2 - The timer event fires when the count matches the period and, in gated mode, when the gate input falls.
// RULE3 - Software stops the timer, sets prescale, source, gating, sync and period, enables the interrupt, then starts it.
// RULE4 - Writing one to control bit 15 starts the counter and writing zero stops it.
// RULE5 - With the idle-halt bit set the counter stops while the chip is idle; cleared, it keeps running.
// RULE6 - With the clock-source bit set, bits 9-8 pick generic input (11), low-power RC (10), dedicated pin (01) or secondary osc (00).
// RULE7 - The gated-accumulate bit enables gated accumulation with the internal clock and is ignored with an external one.
// RULE8 - The prescale field at bits 5-4 divides by 256 (11), 64 (10), 8 (01) or 1 (00).
// RULE9 - With an external clock, bit 2 set synchronizes the input, clear leaves it unsynchronized; ignored for the internal clock.
// RULE10 - Bit 1 set picks the extended source, clear picks the internal clock at the system rate divided by two.
// RULE11 - Control bits 14, 12-10, 7, 3 and 0 ignore writes and read as zero.
// RULE12 - The counter serves as the real-time-clock time base as well as a free-running interval timer.
// RULE13 - The counter may keep running while the processor idles or sleeps, subject to idle-halt.
// RULE14 - A control write while the timer runs resets the prescale counter.
// RULE15 - Each prescaled tick increments the count; on a period match the count returns to zero and the flag is set.
// RULE16 - In gated mode prescaled internal ticks count only while the gate is high, and the gate's fall sets the flag.
package timer_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_OFFSET    = 8'h00;
  localparam logic [7:0] PERIOD_OFFSET     = 8'h04;
  localparam logic [7:0] COUNT_OFFSET      = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFFSET   = 8'h10;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int RUN_BIT       = 15;
  localparam int IDLE_HALT_BIT = 13;
  localparam int EXT_SRC_LSB   = 8;
  localparam int GATE_BIT      = 6;
  localparam int PRESCALE_LSB  = 4;
  localparam int SYNC_BIT      = 2;
  localparam int SRC_BIT       = 1;
  localparam logic [15:0] CONTROL_WMASK = 16'hA376;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET  = 16'hFFFF;

  // ----------------------------------------------------------------
  // Interrupt status bits
  // ----------------------------------------------------------------
  localparam int IRQ_MATCH_BIT = 0;
  localparam int IRQ_GATE_BIT  = 1;
  localparam int IRQ_WIDTH     = 2;

  // ----------------------------------------------------------------
  // Prescale ratios and clocks
  // ----------------------------------------------------------------
  localparam logic [7:0] DIV_256 = 8'hFF;
  localparam logic [7:0] DIV_64  = 8'h3F;
  localparam logic [7:0] DIV_8   = 8'h07;
  localparam logic [7:0] DIV_1   = 8'h00;
  localparam int CLK_PERIOD_NS  = 8;
  localparam int INT_CLK_DIVIDE = 2;

  // External clock choices.
  typedef enum logic [1:0] {
    SRC_SECONDARY = 2'h0,
    SRC_DEDICATED = 2'h1,
    SRC_LOW_POWER_RC_OSC      = 2'h2,
    SRC_GENERIC   = 2'h3
  } ext_src_t;

  // Decoded control word shared by the counter core.
  typedef struct packed {
    logic       run;
    logic       idle_halt;
    ext_src_t   ext_source_select;
    logic       gated_accumulate;
    logic [1:0] prescale_select;
    logic       ext_clock_sync;
    logic       clock_source_select;
  } timer_cfg_t;

endpackage

/* core/timer_prescaler.sv */
// Prescale divider producing one-cycle tick enables.
`timescale 1ns/100ps
module timer_prescaler
  import timer_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Control
  input  wire logic       clear,
  input  wire logic       in_tick,
  input  wire logic [1:0] prescale_select,
  // Divided tick
  output logic            out_tick
);

  logic [7:0] div_reg;
  logic [7:0] limit;

  // Terminal count for each prescale setting.
  always_comb begin
    unique case (prescale_select)
      2'h3: limit = DIV_256;
      2'h2: limit = DIV_64;
      2'h1: limit = DIV_8;
      2'h0: limit = DIV_1;
    endcase
  end

  // Counts input ticks and wraps at the limit.
  always_ff @(posedge core_clk) begin
    if (rst || clear) begin
      div_reg <= 8'h00;
    end else if (in_tick) begin
      div_reg <= (div_reg >= limit) ? 8'h00 : div_reg + 8'h01;
    end
  end

  assign out_tick = in_tick && (div_reg >= limit); // see RULE8

endmodule

/* sim/ext_source_model.sv */
// Behavioural model of the external clock sources and the gate pin seen by the timer.
`timescale 1ns/100ps
module ext_source_model (
  // Clock
  input  wire logic core_clk,
  // Modelled pins
  output logic      generic_timer_input,
  output logic      low_power_rc_osc,
  output logic      dedicated_clock_pin,
  output logic      secondary_osc,
  output logic      gate_in
);
  logic [3:0] ck;

  // Only the chosen source toggles; the others stand low, so a wrong pick counts nothing.
  assign {generic_timer_input, low_power_rc_osc, dedicated_clock_pin, secondary_osc} = ck;

  // All pins idle low until a scenario asks for edges.
  initial begin
    ck = 4'h0;
    gate_in = 1'b0;
  end

  // Sends n rising edges on source s, high for half cycles and low for half plus one between pulses (fast or slow).
  task automatic pulses(input logic [1:0] s, input int n, input int half);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      ck[s] <= 1'b1;
      repeat (half) @(posedge core_clk);
      ck[s] <= 1'b0;
      repeat (half) @(posedge core_clk);
    end
  endtask

  // Moves the gate level just after a clock edge.
  task automatic set_gate(input logic v);
    @(posedge core_clk);
    gate_in <= v;
  endtask
endmodule

/* sim/general_purpose_16bit_timer_tb.sv */
// Self-checking testbench for the 16-bit timer and its APB registers.
`timescale 1ns/100ps
module general_purpose_16bit_timer_tb
  import timer_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        core_clk, rst, psel, penable, pwrite, cpu_idle;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, irq, rtc_tick, er;
  logic        generic_timer_input, low_power_rc_osc, dedicated_clock_pin, secondary_osc, gate_in;
  int          fail_count, comparisons;
  localparam logic [31:0] RUN  = 32'h1 << RUN_BIT;
  localparam logic [31:0] EXT  = 32'h1 << SRC_BIT;
  localparam logic [31:0] GATE = 32'h1 << GATE_BIT;

  // Device under test.
  general_purpose_16bit_timer dut (
    .core_clk            (core_clk),
    .rst                 (rst),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .prdata              (prdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .generic_timer_input (generic_timer_input),
    .low_power_rc_osc    (low_power_rc_osc),
    .dedicated_clock_pin (dedicated_clock_pin),
    .secondary_osc       (secondary_osc),
    .gate_in             (gate_in),
    .cpu_idle            (cpu_idle),
    .irq                 (irq),
    .rtc_tick            (rtc_tick)
  );

  // Far-side clock sources and gate.
  ext_source_model src (
    .core_clk            (core_clk),
    .generic_timer_input (generic_timer_input),
    .low_power_rc_osc    (low_power_rc_osc),
    .dedicated_clock_pin (dedicated_clock_pin),
    .secondary_osc       (secondary_osc),
    .gate_in             (gate_in)
  );

  // Free-running 125 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Prints the verdict and stops the run.
  task automatic end_sim();
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One APB transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fail_count++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Counts edges up to the next time-base pulse; a missing pulse ends the run.
  task automatic wait_rtc(output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (rtc_tick !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      fail_count++;
      end_sim();
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, loose control bits and an unmapped address.
  task automatic t_regs();
    apb(1'b0, CONTROL_OFFSET, 32'h0);
    chk(rd, 32'h0);
    chk(er, 32'h0);
    apb(1'b0, PERIOD_OFFSET, 32'h0);
    chk(rd, 32'hFFFF);
    apb(1'b0, COUNT_OFFSET, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(er, 32'h1);
    apb(1'b1, CONTROL_OFFSET, 32'h7FFF);
    apb(1'b0, CONTROL_OFFSET, 32'h0);
    chk(rd, 32'h2376);
    apb(1'b1, CONTROL_OFFSET, 32'h0);
  endtask

  // Spacing of period events on the time-base pulse for every prescale code.
  task automatic t_prescale();
    int n;
    int g;
    int div [4] = '{1, 8, 64, 256};
    apb(1'b1, PERIOD_OFFSET, 32'h1);
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, CONTROL_OFFSET, 32'h0);
      apb(1'b1, COUNT_OFFSET, 32'h0);
      apb(1'b1, CONTROL_OFFSET, RUN | (32'(p) << PRESCALE_LSB));
      wait_rtc(n);
      wait_rtc(g);
      chk(g, 4 * div[p]);
    end
    apb(1'b1, CONTROL_OFFSET, 32'h0);
  endtask

  // External edges from every source, synchronised or not; the gate bit must be ignored.
  task automatic t_external();
    apb(1'b1, PERIOD_OFFSET, 32'hFFFF);
    for (int s = 0; s < 4; s++) begin
      for (int y = 0; y < 2; y++) begin
        apb(1'b1, CONTROL_OFFSET, 32'h0);
        apb(1'b1, COUNT_OFFSET, 32'h0);
        apb(1'b1, CONTROL_OFFSET, RUN | EXT | GATE | (32'(s) << EXT_SRC_LSB) | (32'(y) << SYNC_BIT));
        src.pulses(2'(s), 5, 3 + 4 * y);
        repeat (6) @(posedge core_clk);
        apb(1'b0, COUNT_OFFSET, 32'h0);
        chk(rd, 32'h5);
      end
    end
  endtask

  // Gated accumulation counts only while the gate is high and flags its fall.
  task automatic t_gated();
    apb(1'b1, IRQ_STATUS_OFFSET, 32'h3);
    apb(1'b1, CONTROL_OFFSET, 32'h0);
    apb(1'b1, COUNT_OFFSET, 32'h0);
    apb(1'b1, CONTROL_OFFSET, RUN | GATE);
    repeat (20) @(posedge core_clk);
    apb(1'b0, COUNT_OFFSET, 32'h0);
    chk(rd, 32'h0);
    src.set_gate(1'b1);
    repeat (40) @(posedge core_clk);
    src.set_gate(1'b0);
    repeat (6) @(posedge core_clk);
    apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, COUNT_OFFSET, 32'h0);
    chk(32'(rd >= 19 && rd <= 22), 32'h1);
    apb(1'b1, CONTROL_OFFSET, 32'h0);
  endtask

  // Match flag raised, then masked, unmasked and cleared by writing one.
  task automatic t_irq();
    apb(1'b1, IRQ_STATUS_OFFSET, 32'h3);
    apb(1'b1, PERIOD_OFFSET, 32'h1);
    apb(1'b1, COUNT_OFFSET, 32'h0);
    apb(1'b1, CONTROL_OFFSET, RUN);
    repeat (8) @(posedge core_clk);
    apb(1'b1, CONTROL_OFFSET, 32'h0);
    apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
    chk(rd, 32'h1);
    chk(irq, 32'h0);
    apb(1'b1, IRQ_MASK_OFFSET, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(irq, 32'h1);
    apb(1'b1, IRQ_MASK_OFFSET, 32'h2);
    repeat (2) @(posedge core_clk);
    chk(irq, 32'h0);
    apb(1'b1, IRQ_MASK_OFFSET, 32'h1);
    apb(1'b1, IRQ_STATUS_OFFSET, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(irq, 32'h0);
    apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
    chk(rd, 32'h0);
  endtask

  // Idle halt, running through idle, and a stopped timer holding its count.
  task automatic t_idle();
    apb(1'b1, PERIOD_OFFSET, 32'hFFFF);
    apb(1'b1, COUNT_OFFSET, 32'h0);
    cpu_idle <= 1'b1;
    apb(1'b1, CONTROL_OFFSET, RUN | (32'h1 << IDLE_HALT_BIT));
    repeat (20) @(posedge core_clk);
    apb(1'b0, COUNT_OFFSET, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, CONTROL_OFFSET, RUN);
    repeat (20) @(posedge core_clk);
    apb(1'b0, COUNT_OFFSET, 32'h0);
    chk(32'(rd > 0), 32'h1);
    cpu_idle <= 1'b0;
    apb(1'b1, CONTROL_OFFSET, 32'h0);
    apb(1'b1, COUNT_OFFSET, 32'h7);
    repeat (20) @(posedge core_clk);
    apb(1'b0, COUNT_OFFSET, 32'h0);
    chk(rd, 32'h7);
  endtask

  // Reset, then every scenario in turn.
  initial begin
    fail_count = 0;
    comparisons = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cpu_idle = 1'b0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_prescale();
    t_external();
    t_gated();
    t_irq();
    t_idle();
    end_sim();
  end
endmodule
